// ===== ppo_ctrl.sv
/*
 * ppo_ctrl: per-port shed priority and overload cutoff inhibit register for
 * a four-port quad, with emergency shutdown shedding.
 * assumes: the serial management front end delivers one-cycle read and write
 * strobes with address and data; the quad reset command arrives as a pulse;
 * the port state machines act on the power-off and clear pulses.
 */
`timescale 1ns/1ps
// Operation
// - shed bit 0 keeps port, 1 removes power
// - shed bits used only when multilevel select 0
// - quad reset clears all four shed bits
// - shutdown event on shutdown pin going high
// - shed ports get full power-off command actions
// - inhibit acts only on powered-good ports
// - inhibit 0 cuts overload, 1 keeps power
// - overcurrent and disconnect still cut when inhibited
// - overload event flagged and interrupts despite inhibit
// - all eight bits read back as written
// - shutdown clears shed ports' detect and classify enables
module ppo_ctrl
    import ppo_pkg::*;
#(
    parameter int unsigned NUM_PORTS = PPO_NUM_PORTS
)
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      clk_en,
    input  wire logic [PPO_ADDR_WIDTH-1:0] reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic [PPO_REG_WIDTH-1:0]  reg_wdata,
    input  wire logic                      reg_rd,
    output logic      [PPO_REG_WIDTH-1:0]  reg_rdata,
    input  wire logic                      quad_reset,
    input  wire logic                      multilevel_priority_select,
    input  wire logic                      emergency_shutdown_input,
    input  wire logic [NUM_PORTS-1:0]      port_power_good,
    input  wire logic [NUM_PORTS-1:0]      port_overload_exceeded,
    input  wire logic [NUM_PORTS-1:0]      port_overcurrent_fault,
    input  wire logic [NUM_PORTS-1:0]      port_pd_disconnected,
    input  wire logic [PPO_NUM_PAIRS-1:0]  port_four_pair_mode,
    output logic      [NUM_PORTS-1:0]      port_shed_on_emergency,
    output logic      [NUM_PORTS-1:0]      port_overload_cutoff_inhibit,
    output logic      [NUM_PORTS-1:0]      port_power_off_command,
    output logic      [NUM_PORTS-1:0]      port_detect_class_clear,
    output logic      [NUM_PORTS-1:0]      two_pair_overload_event,
    output logic      [PPO_NUM_PAIRS-1:0]  four_pair_overload_event,
    output logic                           emergency_shutdown_flag
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // the register packs two fields of one bit per port into 8 bits
    if (NUM_PORTS != PPO_NUM_PORTS) begin : g_bad_ports
        $error("ppo_ctrl: NUM_PORTS must be 4");
    end

    logic [PPO_REG_WIDTH-1:0] ctrl_reg;
    logic [PPO_REG_WIDTH-1:0] ctrl_next;
    logic [PPO_REG_WIDTH-1:0] rdata_reg;
    logic [PPO_REG_WIDTH-1:0] rdata_next;
    logic [NUM_PORTS-1:0]     shed_active;
    logic [NUM_PORTS-1:0]     ovl_evt;
    logic [NUM_PORTS-1:0]     pair_mode_wide;
    logic [NUM_PORTS-1:0]     tp_evt_reg;
    logic [NUM_PORTS-1:0]     tp_evt_next;
    logic [PPO_NUM_PAIRS-1:0] fp_evt_reg;
    logic [PPO_NUM_PAIRS-1:0] fp_evt_next;
    logic                     esd_event;
    logic                     wr_hit;
    logic                     rd_hit;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        wr_hit    = reg_wr & ppo_ctrl_hit(reg_addr);
        rd_hit    = reg_rd & ppo_ctrl_hit(reg_addr);
        ctrl_next = ctrl_reg;
        if (wr_hit) begin
            ctrl_next = reg_wdata;
        end
        if (quad_reset) begin
            // reset command beats a write to the same field
            ctrl_next[PPO_SHED_LSB +: NUM_PORTS] = '0;
        end
        rdata_next = rdata_reg;
        if (rd_hit) begin
            rdata_next = ctrl_reg;
        end else if (reg_rd) begin
            rdata_next = PPO_RDATA_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg  <= PPO_CTRL_RESET;
            rdata_reg <= PPO_RDATA_IDLE;
        end else if (clk_en) begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata                    = rdata_reg;
    assign port_shed_on_emergency       = ctrl_reg[PPO_SHED_LSB +: NUM_PORTS];
    assign port_overload_cutoff_inhibit = ctrl_reg[PPO_INHIBIT_LSB +: NUM_PORTS];

    // ------------------------------------------------------------
    // emergency shutdown
    // ------------------------------------------------------------
    ppo_esd_sync u_esd_sync (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .pin_in     (emergency_shutdown_input),
        .rise_pulse (esd_event)
    );

    assign emergency_shutdown_flag = esd_event;

    // multilevel scheme lives elsewhere; this field then sheds nothing
    assign shed_active = port_shed_on_emergency & {NUM_PORTS{~multilevel_priority_select}};

    // ------------------------------------------------------------
    // per-port cutoff
    // ------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        ppo_port_cut u_cut (
            .sys_clk            (sys_clk),
            .rst_b              (rst_b),
            .clk_en             (clk_en),
            .power_good         (port_power_good[p]),
            .overload_exceeded  (port_overload_exceeded[p]),
            .overcurrent_fault  (port_overcurrent_fault[p]),
            .pd_disconnected    (port_pd_disconnected[p]),
            .cutoff_inhibit     (port_overload_cutoff_inhibit[p]),
            .shed_active        (shed_active[p]),
            .esd_event          (esd_event),
            .power_off_cmd      (port_power_off_command[p]),
            .overload_event     (ovl_evt[p]),
            .detect_class_clear (port_detect_class_clear[p])
        );
    end

    // ------------------------------------------------------------
    // overload event routing
    // ------------------------------------------------------------
    // limit raise by the host ends the condition, not this logic
    always_comb begin
        for (int j = 0; j < PPO_NUM_PAIRS; j++) begin
            pair_mode_wide[2*j]   = port_four_pair_mode[j];
            pair_mode_wide[2*j+1] = port_four_pair_mode[j];
            fp_evt_next[j]        = port_four_pair_mode[j] & (|ovl_evt[2*j +: 2]);
        end
        tp_evt_next = ovl_evt & ~pair_mode_wide;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tp_evt_reg <= '0;
            fp_evt_reg <= '0;
        end else if (clk_en) begin
            tp_evt_reg <= tp_evt_next;
            fp_evt_reg <= fp_evt_next;
        end
    end

    assign two_pair_overload_event  = tp_evt_reg;
    assign four_pair_overload_event = fp_evt_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] fault_cut;
    logic [NUM_PORTS-1:0] any_cut;
    logic [NUM_PORTS-1:0] inhibit_keep;

    assign fault_cut    = port_power_good & (port_overcurrent_fault | port_pd_disconnected);
    assign any_cut      = fault_cut | (port_power_good & port_overload_exceeded & ~port_overload_cutoff_inhibit);
    assign inhibit_keep = port_power_good & port_overload_exceeded & port_overload_cutoff_inhibit
                        & ~port_overcurrent_fault & ~port_pd_disconnected;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_pin_quiet;
        (!emergency_shutdown_input && clk_en) [*3];
    endsequence

    sequence s_pin_rise;
        s_pin_quiet ##1 (emergency_shutdown_input && clk_en) ##1 clk_en [*2];
    endsequence

    sequence s_ovl_onset;
        (clk_en && !port_overload_exceeded[0]) ##1
        (clk_en && port_power_good[0] && port_overload_exceeded[0] && !port_four_pair_mode[0]) ##1
        (clk_en && !port_four_pair_mode[0]);
    endsequence

    a_esd_edge_flag: assert property (s_pin_rise |=> emergency_shutdown_flag)
        else $error("shutdown flag missing after pin rise");
    a_esd_single: assert property (emergency_shutdown_flag && clk_en |=> !emergency_shutdown_flag)
        else $error("shutdown flag lasted more than one cycle");
    a_shed_reset: assert property (quad_reset && clk_en |=> port_shed_on_emergency == '0)
        else $error("quad reset left a shed bit set");
    a_reg_write: assert property (wr_hit && !quad_reset && clk_en |=> ctrl_reg == $past(reg_wdata))
        else $error("register write not stored");
    a_reg_read: assert property (rd_hit && clk_en |=> reg_rdata == $past(ctrl_reg))
        else $error("register read returned wrong value");
    a_shed_off: assert property (emergency_shutdown_flag && clk_en && !multilevel_priority_select
        |=> (port_power_off_command & $past(port_shed_on_emergency)) == $past(port_shed_on_emergency))
        else $error("shed port not powered off");
    a_keep_unshed: assert property (emergency_shutdown_flag && clk_en && any_cut == '0
        |=> (port_power_off_command & ~$past(shed_active)) == '0)
        else $error("unshed port powered off by shutdown");
    a_multilevel_off: assert property (emergency_shutdown_flag && clk_en && multilevel_priority_select
        && any_cut == '0 |=> port_power_off_command == '0)
        else $error("shed field used under multilevel select");
    a_inhibit_keep: assert property (clk_en && !emergency_shutdown_flag
        |=> (port_power_off_command & $past(inhibit_keep)) == '0)
        else $error("inhibited port cut on overload");
    a_fault_cut: assert property (clk_en |=> (port_power_off_command & $past(fault_cut)) == $past(fault_cut))
        else $error("fault did not cut port");
    a_not_good: assert property (clk_en && !emergency_shutdown_flag
        |=> (port_power_off_command & ~$past(port_power_good)) == '0)
        else $error("port cut while not powered good");
    a_detcls_clear: assert property (clk_en |=> port_detect_class_clear
        == ($past(shed_active) & {NUM_PORTS{$past(emergency_shutdown_flag)}}))
        else $error("detect and classify clear mismatch");
    a_ovl_event: assert property (s_ovl_onset |=> two_pair_overload_event[0])
        else $error("overload event not reported");

    // ------------------------------------------------------------
    // register port, freeze and routing checks
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] normal_cut;
    logic                 wr_miss;

    // plain overload cut, the case an inhibit bit of 1 prevents
    assign normal_cut = port_power_good & port_overload_exceeded & ~port_overload_cutoff_inhibit;
    assign wr_miss    = reg_wr & ~ppo_ctrl_hit(reg_addr);

    sequence s_fp_onset;
        (clk_en && !port_overload_exceeded[1]) ##1
        (clk_en && port_power_good[1] && port_overload_exceeded[1] && port_four_pair_mode[0]) ##1
        (clk_en && port_four_pair_mode[0]);
    endsequence

    // stray addresses must neither write nor leak register contents
    a_wr_ignored: assert property (wr_miss && !quad_reset && clk_en |=> $stable(ctrl_reg))
        else $error("write to another address changed the register");
    a_rd_idle: assert property (reg_rd && !rd_hit && clk_en |=> reg_rdata == PPO_RDATA_IDLE)
        else $error("read of another address not idle");
    a_rdata_hold: assert property (!(reg_rd && clk_en) |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // quad reset touches the shed field only and beats a same-cycle write
    a_quad_inh: assert property (quad_reset && !wr_hit && clk_en
        |=> port_overload_cutoff_inhibit == $past(port_overload_cutoff_inhibit))
        else $error("quad reset changed an inhibit bit");
    a_quad_wins: assert property (quad_reset && wr_hit && clk_en |=> port_shed_on_emergency == '0
        && port_overload_cutoff_inhibit == $past(reg_wdata[PPO_INHIBIT_LSB +: NUM_PORTS]))
        else $error("quad reset lost to a write");

    // a low clock enable must park every register, not just the bank
    // pulses stretch while frozen; the port machines must gate on it too
    a_freeze_regs: assert property (!clk_en |=> $stable(ctrl_reg) && $stable(reg_rdata))
        else $error("register state moved while clock enable low");
    a_freeze_outs: assert property (!clk_en |=> $stable(port_power_off_command)
        && $stable(emergency_shutdown_flag) && $stable(two_pair_overload_event))
        else $error("outputs moved while clock enable low");

    // overload path: cut when not inhibited, route events by pair mode
    a_overload_cut: assert property (clk_en
        |=> (port_power_off_command & $past(normal_cut)) == $past(normal_cut))
        else $error("uninhibited overload did not cut port");
    a_off_cause: assert property (clk_en && !emergency_shutdown_flag && any_cut == '0
        |=> port_power_off_command == '0)
        else $error("port cut without a cause");
    a_tp_masked: assert property (clk_en
        |=> (two_pair_overload_event & $past(pair_mode_wide)) == '0)
        else $error("two-pair event raised on a four-pair port");
    a_fp_quiet: assert property (clk_en
        |=> (four_pair_overload_event & ~$past(port_four_pair_mode)) == '0)
        else $error("four-pair event raised on a two-pair pair");
    a_ovl_single: assert property (clk_en && two_pair_overload_event != '0
        |=> (two_pair_overload_event & $past(two_pair_overload_event)) == '0)
        else $error("overload event lasted more than one cycle");
    a_fp_event: assert property (s_fp_onset |=> four_pair_overload_event[0])
        else $error("four-pair overload event not reported");

    // shutdown side: no flag without an edge, clears ride with power-off
    a_flag_needs_pin: assert property (s_pin_quiet |=> !emergency_shutdown_flag)
        else $error("shutdown flag without pin rise");
    a_clr_with_off: assert property (clk_en
        |=> (port_detect_class_clear & ~port_power_off_command) == '0)
        else $error("detect and classify clear without power-off");

endmodule

// ===== ppo_pkg.sv
/*
 * ppo_pkg: constants for the per-port priority and overload control register
 * of one four-port quad.
 * assumes: a serial management front end hands over decoded register strobes.
 */
package ppo_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned PPO_NUM_PORTS   = 4;
    localparam int unsigned PPO_NUM_PAIRS   = 2;
    localparam int unsigned PPO_REG_WIDTH   = 8;
    localparam int unsigned PPO_ADDR_WIDTH  = 8;
    localparam logic [7:0]  PPO_CTRL_ADDR   = 8'h15;
    localparam logic [7:0]  PPO_CTRL_RESET  = 8'h00;
    localparam int unsigned PPO_SHED_LSB    = 4;
    localparam int unsigned PPO_INHIBIT_LSB = 0;
    localparam logic [7:0]  PPO_RDATA_IDLE  = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    // pin to shutdown flag, in enabled clock edges
    localparam int unsigned PPO_ESD_LATENCY = 3;

    function automatic logic ppo_ctrl_hit(input logic [7:0] addr);
        ppo_ctrl_hit = (addr == PPO_CTRL_ADDR);
    endfunction

endpackage

// ===== ppo_esd_sync.sv
/*
 * ppo_esd_sync: two-flop synchroniser and rising-edge detector for the
 * emergency shutdown pin.
 * assumes: pin may be asynchronous; clk_en freezes all state.
 */
`timescale 1ns/1ps
module ppo_esd_sync
    import ppo_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      rise_pulse
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic rise_reg;
    logic rise_next;

    // ------------------------------------------------------------
    // edge detect
    // ------------------------------------------------------------
    // sync1 feeds only sync2, never the edge logic
    always_comb begin
        rise_next = sync2_reg & ~prev_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            rise_reg  <= 1'b0;
        end else if (clk_en) begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            rise_reg  <= rise_next;
        end
    end

    assign rise_pulse = rise_reg;

endmodule

// ===== ppo_port_cut.sv
/*
 * ppo_port_cut: power-off and overload event decision for one port.
 * assumes: fault and overload inputs are already qualified by the port
 * timers (overload means limit exceeded past its tolerance time).
 */
`timescale 1ns/1ps
module ppo_port_cut
    import ppo_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic power_good,
    input  wire logic overload_exceeded,
    input  wire logic overcurrent_fault,
    input  wire logic pd_disconnected,
    input  wire logic cutoff_inhibit,
    input  wire logic shed_active,
    input  wire logic esd_event,
    output logic      power_off_cmd,
    output logic      overload_event,
    output logic      detect_class_clear
);

    logic off_reg;
    logic off_next;
    logic ovl_evt_reg;
    logic ovl_evt_next;
    logic clr_reg;
    logic clr_next;
    logic ovl_prev_reg;
    logic cut_cause;

    // ------------------------------------------------------------
    // decision
    // ------------------------------------------------------------
    always_comb begin
        // inhibit only masks the overload term, faults still cut
        cut_cause    = power_good & ((overload_exceeded & ~cutoff_inhibit)
                     | overcurrent_fault | pd_disconnected);
        off_next     = cut_cause | (esd_event & shed_active);
        // one event per overload onset, reported even when inhibited
        ovl_evt_next = power_good & overload_exceeded & ~ovl_prev_reg;
        clr_next     = esd_event & shed_active;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            off_reg      <= 1'b0;
            ovl_evt_reg  <= 1'b0;
            clr_reg      <= 1'b0;
            ovl_prev_reg <= 1'b0;
        end else if (clk_en) begin
            off_reg      <= off_next;
            ovl_evt_reg  <= ovl_evt_next;
            clr_reg      <= clr_next;
            ovl_prev_reg <= power_good & overload_exceeded;
        end
    end

    assign power_off_cmd      = off_reg;
    assign overload_event     = ovl_evt_reg;
    assign detect_class_clear = clr_reg;

endmodule

// ===== ppo_host_model.sv
/*
 * ppo_host_model: host side of the register port, one strobe per access.
 * assumes: called from the bench by hierarchical task; drives at the falling edge.
 */
`timescale 1ns/1ps
module ppo_host_model (
    input  wire logic       sys_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // ------------------------------------------------------------
    // single byte access
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr    = wr;
        reg_rd    = !wr;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // released bus must not keep showing the last value
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// ===== port_priority_overload_control_tb.sv
/*
 * port_priority_overload_control_tb: register, shutdown and cutoff tests.
 * assumes: ppo_ctrl with four ports; inputs change on the falling edge.
 */
`timescale 1ns/1ps
module port_priority_overload_control_tb;
    import ppo_pkg::*;

    logic       sys_clk;
    logic       rst_b;
    logic       ce;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       quad_reset;
    logic       mlp;
    logic       pin;
    logic [3:0] pg;
    logic [3:0] ovl;
    logic [3:0] ovc;
    logic [3:0] pdd;
    logic [1:0] mode4;
    logic [3:0] shed;
    logic [3:0] inh;
    logic [3:0] off;
    logic [3:0] clr;
    logic [3:0] ev2;
    logic [1:0] ev4;
    logic       flag;
    int         failures;
    int         check_count;
    int         cycles;

    ppo_host_model ppo_host_model_inst (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    ppo_ctrl #(.NUM_PORTS(4)) ppo_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .quad_reset(quad_reset), .multilevel_priority_select(mlp),
        .emergency_shutdown_input(pin), .port_power_good(pg), .port_overload_exceeded(ovl),
        .port_overcurrent_fault(ovc), .port_pd_disconnected(pdd), .port_four_pair_mode(mode4),
        .port_shed_on_emergency(shed), .port_overload_cutoff_inhibit(inh),
        .port_power_off_command(off), .port_detect_class_clear(clr),
        .two_pair_overload_event(ev2), .four_pair_overload_event(ev4),
        .emergency_shutdown_flag(flag));

    // ------------------------------------------------------------
    // clock, timeout, checks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // run needs about 106 cycles; ceiling well above it
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected bits at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ppo_host_model_inst.access(1'b1, a, d);
        @(negedge sys_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        ppo_host_model_inst.access(1'b0, a, 8'h00);
        @(negedge sys_clk);
        chk_byte(reg_rdata, exp);
    endtask

    // pin rise held high: one flag, shed ports get off and clear pulses
    task automatic esd(input logic sel, input logic [3:0] exp);
        int         flags;
        logic [3:0] off_seen;
        logic [3:0] clr_seen;
        flags    = 0;
        off_seen = 4'h0;
        clr_seen = 4'h0;
        mlp      = sel;
        @(negedge sys_clk);
        pin = 1'b1;
        repeat (12) begin
            @(negedge sys_clk);
            flags    = flags + int'(flag === 1'b1);
            off_seen = off_seen | off;
            clr_seen = clr_seen | clr;
        end
        pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk_nib(4'(flags), 4'h1);
        chk_nib(off_seen, exp);
        chk_nib(clr_seen, exp);
        mlp = 1'b0;
    endtask

    task automatic ovl_run(input logic [1:0] m, input logic [3:0] g, input logic [3:0] o,
                           input logic [3:0] e2, input logic [1:0] e4, input logic [3:0] eoff);
        logic [3:0] s2;
        logic [1:0] s4;
        logic [3:0] so;
        s2    = 4'h0;
        s4    = 2'h0;
        so    = 4'h0;
        mode4 = m;
        pg    = g;
        ovl   = o;
        repeat (5) begin
            @(negedge sys_clk);
            s2 = s2 | ev2;
            s4 = s4 | ev4;
            so = so | off;
        end
        ovl = 4'h0;
        pg  = 4'h0;
        repeat (2) @(negedge sys_clk);
        chk_nib(s2, e2);
        chk_nib({2'b00, s4}, {2'b00, e4});
        chk_nib(so, eoff);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b       = 1'b0;
        ce          = 1'b1;
        quad_reset  = 1'b0;
        mlp         = 1'b0;
        pin         = 1'b0;
        pg          = 4'h0;
        ovl         = 4'h0;
        ovc         = 4'h0;
        pdd         = 4'h0;
        mode4       = 2'h0;
        failures    = 0;
        check_count = 0;
        cycles      = 0;
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        rd_chk(8'h15, 8'h00);
        wr(8'h15, 8'hA5);
        rd_chk(8'h15, 8'hA5);
        chk_nib(shed, 4'hA);
        chk_nib(inh, 4'h5);
        wr(8'h14, 8'hFF);
        rd_chk(8'h15, 8'hA5);
        rd_chk(8'h14, 8'h00);
        wr(8'h15, 8'h5A);
        rd_chk(8'h15, 8'h5A);
        quad_reset = 1'b1;
        @(negedge sys_clk);
        quad_reset = 1'b0;
        @(negedge sys_clk);
        chk_nib(shed, 4'h0);
        chk_nib(inh, 4'hA);
        // write with clock enable low must leave the register untouched
        ce = 1'b0;
        wr(8'h15, 8'hFF);
        chk_nib(inh, 4'hA);
        ce = 1'b1;
        rd_chk(8'h15, 8'h0A);
        wr(8'h15, 8'h53);
        esd(1'b0, 4'h5);
        esd(1'b1, 4'h0);
        wr(8'h15, 8'h05);
        ovl_run(2'b00, 4'b0011, 4'b0111, 4'b0011, 2'b00, 4'b0010);
        ovl_run(2'b01, 4'b1111, 4'b1111, 4'b1100, 2'b01, 4'b1010);
        for (int f = 0; f < 2; f++) begin
            pg  = 4'b0001;
            ovc = (f == 0) ? 4'b0001 : 4'b0000;
            pdd = (f == 1) ? 4'b0001 : 4'b0000;
            repeat (3) @(negedge sys_clk);
            chk_nib(off, 4'b0001);
            pg  = 4'h0;
            ovc = 4'h0;
            pdd = 4'h0;
            repeat (2) @(negedge sys_clk);
        end
        end_of_test();
    end
endmodule
